// ==== sms_pkg.sv ====
// sms_pkg: constants, carriers and state codes of the serial shift unit.
// assumes: one bus clock domain plus the incoming serial clock domain.
package sms_pkg;

    // ------------------------------------------------------------
    // transfer shape and crossing depth
    // ------------------------------------------------------------
    localparam int SYNC_STAGES = 2;
    localparam int BITS_PER_XFER = 8;
    localparam logic [4:0] LAST_HALF = 5'h0F; // 16 half bits a byte
    localparam logic [4:0] LAST_SAMPLE_HALF = 5'h0E;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // ------------------------------------------------------------
    // bus cycles per serial bit for each rate code
    // ------------------------------------------------------------
    localparam int DIVIDE_BY_TWO_RATE = 2;
    localparam int RATE_DIV_EIGHT = 8;
    localparam int DIVIDE_MID_RATE = 32;
    localparam int DIVIDE_SLOWEST_RATE = 128;
    localparam int TX_EMPTY_RETURN = 2; // cycles, buffer to shift load

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [6:0] DIV_RESET = 7'h00;
    localparam logic [3:0] SYNC_RESET = 4'h8; // select pin idles high

    // control bits, quasi static while the port is enabled
    typedef struct packed {
        logic enable;     // port_enable_bit
        logic master;     // master_select_bit
        logic cpha;       // clock phase
        logic cpol;       // clock polarity
        logic rate_high;  // rate_select_high
        logic rate_low;   // rate_select_low
    } sms_cfg_t;

    // pin drivers, enables high while driving
    typedef struct packed {
        logic sck_o;
        logic sck_oe;
        logic mosi_o;
        logic mosi_oe;
        logic miso_o;
        logic miso_oe;
    } sms_pins_t;

    typedef enum logic [2:0] {
        MS_IDLE = 3'b001,
        MS_ARMED = 3'b010,
        MS_RUN = 3'b100
    } sms_mstate_t;

endpackage : sms_pkg

// ==== sms_sync.sv ====
// sms_sync: two flip-flop level synchroniser, one pair per bit.
// assumes: each bit is a level or a toggle, never a multi-bit word.
module sms_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,              // destination clock
    input wire logic rst,              // synchronous, active high
    input wire logic [WIDTH-1:0] d,    // asynchronous levels
    output logic [WIDTH-1:0] q         // synchronised levels
);

    logic [WIDTH-1:0] meta_reg;

    if (WIDTH < 1) begin : g_bad_width
        $error("sms_sync needs WIDTH of at least one");
    end

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end

endmodule : sms_sync

// ==== sms_shift_unit.sv ====
// sms_shift_unit: full duplex serial port, master or slave, 8-bit words.
// assumes: control bits change only while the port is disabled; the
// incoming serial clock is a clock of its own, unrelated to ref_clk.

// Overview of operation
// - master when master select set, else slave with serial clock input
// - transfer end moves received byte to rx data and sets rx full
// - two rate bits set master bit rate; master clock drives slave shifter
// - disable sets tx empty, aborts, clears shifter and counters, frees pins
// - slave accepts any serial clock up to the bus clock rate
// - slave loads new byte only if written before master starts
// - byte written during a transfer waits in the buffer until its end
// - slave starts on first clock edge (phase 1) or select fall (phase 0)
// - polarity sets idle level; phase picks one of two formats
// - slave drives miso only while its select is low
// - phase 0 slave drives msb from select fall; data loaded before it
// - phase 1 slave drives msb at first clock edge; data loaded before
// - no buffer to shifter load once a transfer has begun
// - phase 1 master drives mosi on first edge; select may stay low
// - master write starts transfer; phase sets first half bit of clock
// - baud divider runs free only while enabled and master
// - master start delay at most one bit time: 2, 8, 32 or 128 cycles
// - master queued byte starts right after the previous transfer
// - without a new write a slave sends the last shifter word again; a master starts no transfer
// - idle side sets tx empty within two cycles of a write
// - busy slave defers shifter load until its transfer completes
module sms_shift_unit (
    input wire logic ref_clk,            // bus clock, 40 MHz
    input wire logic srst,               // synchronous reset, active high
    input wire sms_pkg::sms_cfg_t cfg,   // control bits
    input wire logic wr_strobe,          // data register write pulse
    input wire logic [7:0] wr_data,      // byte to send
    input wire logic rx_read,            // rx data read pulse, clears flag
    output logic [7:0] rx_data,          // receive data register
    output logic rx_full_flag,           // received byte waiting
    output logic tx_buffer_empty_flag,   // buffer can take a byte
    output logic xfer_active,            // transfer in progress
    input wire logic serial_clock_pin,   // slave serial clock, link clock
    input wire logic slave_select_n_pin, // slave select, active low
    input wire logic mosi_in,            // mosi pin level
    input wire logic miso_in,            // miso pin level
    output sms_pkg::sms_pins_t pins      // pin drivers and enables
);
    import sms_pkg::*;

    // ------------------------------------------------------------
    // mode decode and input synchronisers
    // ------------------------------------------------------------
    logic run_en;
    logic slv_en;
    logic lk_rx_tgl_reg;
    logic lk_start_tgl_reg;
    logic [3:0] sync_q;
    logic ss_low_s;
    logic ss_low_d_reg;
    logic miso_s;
    logic rx_tgl_d_reg;
    logic start_tgl_d_reg;
    logic rx_edge;
    logic start_edge;

    assign run_en = cfg.enable & cfg.master;
    assign slv_en = cfg.enable & ~cfg.master;

    sms_sync #(.WIDTH(4), .RST_VAL(SYNC_RESET)) u_sync (
        .clk(ref_clk),
        .rst(srst),
        .d({slave_select_n_pin, miso_in, lk_rx_tgl_reg, lk_start_tgl_reg}),
        .q(sync_q)
    );

    assign ss_low_s = ~sync_q[3];
    assign miso_s = sync_q[2];
    assign rx_edge = sync_q[1] ^ rx_tgl_d_reg;
    assign start_edge = sync_q[0] ^ start_tgl_d_reg;

    // edge detect on the synchronised copies only
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ss_low_d_reg <= 1'b0;
            rx_tgl_d_reg <= 1'b0;
            start_tgl_d_reg <= 1'b0;
        end else begin
            ss_low_d_reg <= ss_low_s;
            rx_tgl_d_reg <= sync_q[1];
            start_tgl_d_reg <= sync_q[0];
        end
    end

    // ------------------------------------------------------------
    // baud generator
    // ------------------------------------------------------------
    logic [6:0] div_cnt_reg;
    logic [6:0] div_last;
    logic half_tick;
    logic bit_tick;

    // bus cycles per bit minus one, from the two rate bits
    always_comb begin
        unique case ({cfg.rate_high, cfg.rate_low})
            2'b00: div_last = 7'(DIVIDE_BY_TWO_RATE - 1);
            2'b01: div_last = 7'(RATE_DIV_EIGHT - 1);
            2'b10: div_last = 7'(DIVIDE_MID_RATE - 1);
            2'b11: div_last = 7'(DIVIDE_SLOWEST_RATE - 1);
        endcase
    end

    // free running; stopped and cleared to save power when not master
    always_ff @(posedge ref_clk) begin
        if (srst || !run_en) begin
            div_cnt_reg <= DIV_RESET;
        end else if (div_cnt_reg == div_last) begin
            div_cnt_reg <= DIV_RESET;
        end else begin
            div_cnt_reg <= div_cnt_reg + 7'h01;
        end
    end

    assign bit_tick = run_en && (div_cnt_reg == div_last);
    assign half_tick = bit_tick || (run_en && (div_cnt_reg == div_last >> 1));

    // ------------------------------------------------------------
    // transmit buffer and shift word
    // ------------------------------------------------------------
    sms_mstate_t mstate_reg;
    logic [4:0] half_reg;
    logic [7:0] buf_reg;
    logic buf_full_reg;
    logic [7:0] tx_word_reg;
    logic slv_busy_reg;
    logic m_done;
    logic load_ok;
    logic load_now;

    assign m_done = (mstate_reg == MS_RUN) && half_tick
        && (half_reg == LAST_HALF);

    // a phase 0 slave is committed from the select fall onward
    always_comb begin
        if (run_en) begin
            load_ok = (mstate_reg == MS_IDLE) || m_done;
        end else begin
            load_ok = slv_en && !slv_busy_reg
                && !(!cfg.cpha && ss_low_s);
        end
    end

    assign load_now = buf_full_reg && load_ok;

    // write sets full, a load empties it; a write in the load cycle wins
    always_ff @(posedge ref_clk) begin
        if (srst || !cfg.enable) begin
            buf_full_reg <= 1'b0;
            buf_reg <= BYTE_RESET;
        end else if (wr_strobe) begin
            buf_full_reg <= 1'b1;
            buf_reg <= wr_data;
        end else if (load_now) begin
            buf_full_reg <= 1'b0;
        end
    end

    // word being sent; kept when nothing new arrives, so it repeats
    always_ff @(posedge ref_clk) begin
        if (srst || !cfg.enable) begin
            tx_word_reg <= BYTE_RESET;
        end else if (load_now) begin
            tx_word_reg <= buf_reg;
        end
    end

    assign tx_buffer_empty_flag = ~buf_full_reg;

    // ------------------------------------------------------------
    // master sequencer: 16 half bits a byte
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst || !run_en) begin
            mstate_reg <= MS_IDLE;
            half_reg <= 5'h00;
        end else begin
            unique case (mstate_reg)
                MS_IDLE: begin
                    half_reg <= 5'h00;
                    if (buf_full_reg) begin
                        // start on a bit boundary, at most a bit away
                        mstate_reg <= bit_tick ? MS_RUN : MS_ARMED;
                    end
                end
                MS_ARMED: begin
                    if (bit_tick) begin
                        mstate_reg <= MS_RUN;
                    end
                end
                MS_RUN: begin
                    if (m_done) begin
                        half_reg <= 5'h00;
                        mstate_reg <= buf_full_reg ? MS_RUN : MS_IDLE;
                    end else if (half_tick) begin
                        half_reg <= half_reg + 5'h01;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // master pins, registered to keep the clock pin glitch free
    // ------------------------------------------------------------
    logic sck_reg;
    logic mosi_reg;
    logic sck_active;

    // phase 0 idles the first half bit; phase 1 leads with an edge
    assign sck_active = (mstate_reg == MS_RUN)
        && (half_reg[0] ^ cfg.cpha);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sck_reg <= 1'b0;
            mosi_reg <= 1'b0;
        end else begin
            sck_reg <= cfg.cpol ^ sck_active;
            mosi_reg <= tx_word_reg[~half_reg[3:1]];
        end
    end

    // ------------------------------------------------------------
    // master receive: sample at the end of even half bits, delayed to match
    // the output register and the miso synchroniser
    // ------------------------------------------------------------
    localparam int SAMP_DLY = SYNC_STAGES + 1;
    logic [SAMP_DLY-1:0] samp_pipe_reg;
    logic [SAMP_DLY-1:0] last_pipe_reg;
    logic [7:0] m_rx_sh_reg;
    logic m_rx_done;
    logic samp_now;

    assign samp_now = (mstate_reg == MS_RUN) && half_tick && !half_reg[0];

    always_ff @(posedge ref_clk) begin
        if (srst || !run_en) begin
            samp_pipe_reg <= '0;
            last_pipe_reg <= '0;
            m_rx_sh_reg <= BYTE_RESET;
        end else begin
            samp_pipe_reg <= {samp_pipe_reg[SAMP_DLY-2:0], samp_now};
            last_pipe_reg <= {last_pipe_reg[SAMP_DLY-2:0],
                samp_now && (half_reg == LAST_SAMPLE_HALF)};
            if (samp_pipe_reg[SAMP_DLY-1]) begin
                m_rx_sh_reg <= {m_rx_sh_reg[6:0], miso_s};
            end
        end
    end

    assign m_rx_done = last_pipe_reg[SAMP_DLY-1];

    // ------------------------------------------------------------
    // slave busy tracking in the bus domain
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst || !slv_en || !ss_low_s) begin
            slv_busy_reg <= 1'b0;
        end else if ((!cfg.cpha && !ss_low_d_reg)
            || (cfg.cpha && start_edge)) begin
            slv_busy_reg <= 1'b1;
        end else if (rx_edge) begin
            slv_busy_reg <= 1'b0;
        end
    end

    assign xfer_active = (mstate_reg == MS_RUN) || slv_busy_reg;

    // ------------------------------------------------------------
    // link domain: slave shifter on the incoming serial clock
    // ------------------------------------------------------------
    logic lclk;
    logic lk_rst;
    logic [2:0] lk_samp_cnt_reg;
    logic [2:0] lk_drive_cnt_reg;
    logic [6:0] lk_rx_sh_reg;
    logic [7:0] lk_rx_byte_reg;

    // sampling edge becomes the rising edge of lclk; the control bits
    // are static while enabled, so the xor adds no edges
    assign lclk = serial_clock_pin ^ cfg.cpol ^ cfg.cpha;
    assign lk_rst = slave_select_n_pin | ~slv_en;

    // shift in on the sampling edge, any rate up to the bus clock
    always_ff @(posedge lclk or posedge lk_rst) begin
        if (lk_rst) begin
            lk_samp_cnt_reg <= 3'h0;
            lk_rx_sh_reg <= 7'h00;
        end else begin
            lk_samp_cnt_reg <= lk_samp_cnt_reg + 3'h1;
            lk_rx_sh_reg <= {lk_rx_sh_reg[5:0], mosi_in};
        end
    end

    // received byte is held until the next eighth bit, long enough
    // for the bus side to take it after the toggle crosses
    always_ff @(posedge lclk or posedge srst) begin
        if (srst) begin
            lk_rx_byte_reg <= BYTE_RESET;
            lk_rx_tgl_reg <= 1'b0;
        end else if (!lk_rst && lk_samp_cnt_reg == LAST_BIT) begin
            lk_rx_byte_reg <= {lk_rx_sh_reg, mosi_in};
            lk_rx_tgl_reg <= ~lk_rx_tgl_reg;
        end
    end

    // shift out on the other edge; index 0 means msb
    always_ff @(negedge lclk or posedge lk_rst) begin
        if (lk_rst) begin
            lk_drive_cnt_reg <= 3'h0;
        end else begin
            lk_drive_cnt_reg <= lk_samp_cnt_reg;
        end
    end

    // phase 1: a drive edge with no bits counted opens a transfer
    always_ff @(negedge lclk or posedge srst) begin
        if (srst) begin
            lk_start_tgl_reg <= 1'b0;
        end else if (!lk_rst && cfg.cpha && lk_samp_cnt_reg == 3'h0) begin
            lk_start_tgl_reg <= ~lk_start_tgl_reg;
        end
    end

    // ------------------------------------------------------------
    // receive data register
    // ------------------------------------------------------------
    // the link byte is stable for a whole byte time after its toggle
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rx_data <= BYTE_RESET;
            rx_full_flag <= 1'b0;
        end else if (m_rx_done || (slv_en && rx_edge)) begin
            // the last master bit lands in the shifter on this same edge
            rx_data <= m_rx_done ? {m_rx_sh_reg[6:0], miso_s}
                : lk_rx_byte_reg;
            rx_full_flag <= 1'b1; // set wins over a read
        end else if (rx_read) begin
            rx_full_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // pin drivers; the shift word is held still while a slave is busy or, in phase 0,
    // selected, which is what makes reading it across domains safe
    // ------------------------------------------------------------
    assign pins.sck_o = sck_reg;
    assign pins.sck_oe = run_en;
    assign pins.mosi_o = mosi_reg;
    assign pins.mosi_oe = run_en;
    assign pins.miso_o = tx_word_reg[~lk_drive_cnt_reg];
    assign pins.miso_oe = slv_en & ~slave_select_n_pin;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // helper: cycles spent armed, bounds the start delay without a
    // long repetition in the property
    logic [7:0] arm_cnt_reg;

    always_ff @(posedge ref_clk) begin
        if (srst || mstate_reg != MS_ARMED) begin
            arm_cnt_reg <= 8'h00;
        end else begin
            arm_cnt_reg <= arm_cnt_reg + 8'h01;
        end
    end

    sequence s_armed;
        mstate_reg == MS_ARMED;
    endsequence

    sequence s_running;
        mstate_reg == MS_RUN;
    endsequence

    a_rx_capture: assert property (
        @(posedge ref_clk) disable iff (srst)
        m_rx_done |=> rx_full_flag && rx_data == m_rx_sh_reg)
        else $error("received byte not moved to rx data");

    a_disable_abort: assert property (
        @(posedge ref_clk) disable iff (srst)
        !cfg.enable |=> tx_buffer_empty_flag && !xfer_active
            && tx_word_reg == BYTE_RESET)
        else $error("disable did not abort and empty");

    a_pins_released: assert property (
        @(posedge ref_clk) disable iff (srst)
        !cfg.enable |-> !pins.sck_oe && !pins.mosi_oe && !pins.miso_oe)
        else $error("pins driven while disabled");

    a_miso_select: assert property (
        @(posedge ref_clk) disable iff (srst)
        pins.miso_oe |-> !slave_select_n_pin && !cfg.master)
        else $error("miso driven while not selected");

    a_start_delay: assert property (
        @(posedge ref_clk) disable iff (srst || !run_en)
        s_armed |-> arm_cnt_reg < {1'b0, div_last})
        else $error("master start later than one bit time");

    a_busy_hold: assert property (
        @(posedge ref_clk) disable iff (srst || !cfg.enable)
        slv_busy_reg && $past(slv_busy_reg) |-> $stable(tx_word_reg))
        else $error("shift word changed during slave transfer");

    a_empty_return: assert property (
        @(posedge ref_clk) disable iff (srst || !cfg.enable)
        wr_strobe && !buf_full_reg && load_ok && !xfer_active
            ##1 !wr_strobe |-> ##[0:1] tx_buffer_empty_flag)
        else $error("tx empty not set again in two cycles");

    a_baud_off: assert property (
        @(posedge ref_clk) disable iff (srst)
        !run_en |=> div_cnt_reg == DIV_RESET && !bit_tick)
        else $error("baud divider ran outside master mode");

    a_back_to_back: assert property (
        @(posedge ref_clk) disable iff (srst || !run_en)
        m_done && buf_full_reg |=> s_running
            and (half_reg == 5'h00 && !buf_full_reg))
        else $error("queued byte did not follow at once");

    a_idle_clock: assert property (
        @(posedge ref_clk) disable iff (srst)
        run_en && $past(mstate_reg) == MS_IDLE
            && $past(run_en) |-> pins.sck_o == $past(cfg.cpol))
        else $error("master clock not at idle level");

endmodule : sms_shift_unit

// ==== sms_far_end.sv ====
// sms_far_end: far side of the serial link, slave half and master half.
// assumes: the bench resolves each wire from the shift unit's pin enables; this side has none.
module sms_far_end (
    input wire logic cpol,     // clock polarity of the link
    input wire logic cpha,     // clock phase of the link
    input wire logic sck_in,   // serial clock level on the wire
    input wire logic mosi_in,  // mosi level on the wire
    input wire logic miso_in,  // miso level on the wire
    output logic sck_out,      // clock when this side is master
    output logic ss_n_out,     // select when this side is master
    output logic mosi_out,     // data when this side is master
    output logic miso_out      // data when this side is slave
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] s_tx = 8'hA5;
    logic [7:0] s_rx = 8'h00;
    logic [7:0] m_rx = 8'h00;
    logic s_on = 1'b0;
    int ne = 0;
    int k;
    wire logic lk = sck_in ^ cpol ^ cpha; // rising = sampling edge
    // select idles high so a master never sees itself chosen
    initial begin
        sck_out = 1'b0;
        ss_n_out = 1'b1;
        mosi_out = 1'b0;
    end
    // slave half: sample on one edge, move on the other
    always @(posedge lk) if (s_on) s_rx <= {s_rx[6:0], mosi_in};
    always @(negedge lk) if (s_on) ne <= ne + 1;
    assign k = (ne > cpha) ? ne - cpha : 0;
    // off frame shows the inverse of the last bit, never a held value
    assign miso_out = s_on ? s_tx[3'(7 - k)] : ~s_tx[0];
    // master half: clock runs only inside a frame, 30 ns a period
    task automatic run_master(input logic [7:0] b);
        mosi_out = b[7];
        ss_n_out = 1'b0;
        #45;
        for (int i = 0; i < 8; i++) begin
            if (!cpha) m_rx = {m_rx[6:0], miso_in};
            sck_out = ~cpol;
            if (cpha) mosi_out = b[7 - i];
            #15;
            if (cpha) m_rx = {m_rx[6:0], miso_in};
            sck_out = cpol;
            if (!cpha && i < 7) mosi_out = b[6 - i];
            #15;
        end
        #45;
        ss_n_out = 1'b1;
        mosi_out = ~mosi_out;
    endtask : run_master
endmodule : sms_far_end

// ==== test_spi_master_slave_shift_unit.sv ====
// test_spi_master_slave_shift_unit: bench for the serial shift unit.
// assumes: sms_far_end stands on the wires; bench drives control bits.
module test_spi_master_slave_shift_unit import sms_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    sms_cfg_t cfg = '0;
    logic wr_strobe = 1'b0;
    logic rx_read = 1'b0;
    logic [7:0] wr_data = 8'h00;
    logic [7:0] rx_data;
    logic rx_full_flag, tx_buffer_empty_flag, xfer_active;
    sms_pins_t pins;
    logic p_sck, p_ss_n, p_mosi, p_miso;
    int n_mismatch = 0;
    int tests_run = 0;
    int dv [4] = '{DIVIDE_BY_TWO_RATE, RATE_DIV_EIGHT, DIVIDE_MID_RATE,
                   DIVIDE_SLOWEST_RATE};
    // wire levels follow whoever has its enable up
    wire logic sck_w = pins.sck_oe ? pins.sck_o : p_sck;
    wire logic mosi_w = pins.mosi_oe ? pins.mosi_o : p_mosi;
    wire logic miso_w = pins.miso_oe ? pins.miso_o : p_miso;
    sms_shift_unit i_dut (.ref_clk, .srst, .cfg, .wr_strobe, .wr_data,
        .rx_read, .rx_data, .rx_full_flag, .tx_buffer_empty_flag,
        .xfer_active, .serial_clock_pin(sck_w), .slave_select_n_pin(p_ss_n),
        .mosi_in(mosi_w), .miso_in(miso_w), .pins);
    sms_far_end i_far (.cpol(cfg.cpol), .cpha(cfg.cpha), .sck_in(sck_w),
        .mosi_in(mosi_w), .miso_in(miso_w), .sck_out(p_sck),
        .ss_n_out(p_ss_n), .mosi_out(p_mosi), .miso_out(p_miso));
    always #12.5 ref_clk = ~ref_clk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic setcfg(input logic en, ms, ph, pl, input logic [1:0] r);
        @(posedge ref_clk);
        cfg.enable <= 1'b0;
        @(posedge ref_clk);
        cfg <= '{en, ms, ph, pl, r[1], r[0]};
    endtask : setcfg
    task automatic wr(input logic [7:0] b);
        @(posedge ref_clk);
        wr_strobe <= 1'b1;
        wr_data <= b;
        @(posedge ref_clk);
        wr_strobe <= 1'b0;
    endtask : wr
    // bounded wait for a landed byte, then read it away
    task automatic wait_rx(output logic [7:0] b);
        int n;
        n = 0;
        while (rx_full_flag !== 1'b1 && n < 4000) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk({7'h00, n < 4000}, 8'h01);
        b = rx_data;
        @(posedge ref_clk);
        rx_read <= 1'b1;
        @(posedge ref_clk);
        rx_read <= 1'b0;
        #1;
    endtask : wait_rx
    task automatic master_modes();
        int n;
        logic [7:0] got;
        for (int i = 0; i < 4; i++) begin
            setcfg(1'b0, 1'b1, i[0], i[1], 2'(i));
            setcfg(1'b1, 1'b1, i[0], i[1], 2'(i));
            i_far.s_tx = 8'hC3 + 8'(i);
            // let the wire settle on the enabled clock before listening
            @(posedge ref_clk);
            #1;
            i_far.ne = 0;
            i_far.s_on = 1'b1;
            chk({7'h00, pins.sck_o}, {7'h00, i[1]});
            wr(8'h5A ^ 8'(i));
            n = 0;
            while (xfer_active !== 1'b1 && n < 300) begin
                @(posedge ref_clk);
                #1;
                n++;
            end
            chk({7'h00, n <= dv[i] + 2}, 8'h01);
            wait_rx(got);
            chk(got, 8'hC3 + 8'(i));
            chk(i_far.s_rx, 8'h5A ^ 8'(i));
            i_far.s_on = 1'b0;
        end
    endtask : master_modes
    task automatic master_queue();
        logic [7:0] got;
        setcfg(1'b0, 1'b1, 1'b1, 1'b0, 2'b00);
        setcfg(1'b1, 1'b1, 1'b1, 1'b0, 2'b00);
        i_far.s_tx = 8'h81;
        i_far.ne = 0;
        i_far.s_on = 1'b1;
        wr(8'hF0);
        repeat (2) @(posedge ref_clk);
        #1;
        chk({7'h00, tx_buffer_empty_flag}, 8'h01);
        wr(8'h0F);
        wait_rx(got);
        chk({7'h00, xfer_active}, 8'h01);
        chk(got, 8'h81);
        wait_rx(got);
        chk(i_far.s_rx, 8'h0F);
        i_far.s_on = 1'b0;
    endtask : master_queue
    task automatic slave_modes();
        logic [7:0] got;
        for (int c = 0; c < 2; c++) begin
            setcfg(1'b0, 1'b0, c[0], ~c[0], 2'b11);
            i_far.sck_out = ~c[0];
            setcfg(1'b1, 1'b0, c[0], ~c[0], 2'b11);
            wr(8'h96);
            @(posedge ref_clk);
            #1;
            chk({7'h00, pins.miso_oe}, 8'h00);
            i_far.run_master(8'h69);
            chk(i_far.m_rx, 8'h96);
            wait_rx(got);
            chk(got, 8'h69);
            i_far.run_master(8'h3C);
            chk(i_far.m_rx, 8'h96);
            wait_rx(got);
            chk(got, 8'h3C);
        end
    endtask : slave_modes
    task automatic master_abort();
        setcfg(1'b0, 1'b1, 1'b0, 1'b0, 2'b11);
        setcfg(1'b1, 1'b1, 1'b0, 1'b0, 2'b11);
        wr(8'hA5);
        repeat (200) @(posedge ref_clk);
        cfg.enable <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        chk({4'h0, tx_buffer_empty_flag, xfer_active, pins.sck_oe,
             pins.mosi_oe}, 8'h08);
    endtask : master_abort
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk(rx_data, BYTE_RESET);
        chk({7'h00, tx_buffer_empty_flag}, 8'h01);
        master_modes();
        master_queue();
        slave_modes();
        master_abort();
        complete_run();
    end
    // whole run is some two thousand cycles; this is far beyond it
    initial begin
        #2000000;
        n_mismatch++;
        $display("Error at %0t: run did not finish", $time);
        complete_run();
    end
endmodule : test_spi_master_slave_shift_unit
